//--- logic/adc_conv_ctl.sv
// Converter control end: mode/channel and control registers, trigger,
// channel sequencer and byte-wise result readout with a lower-byte latch.
// Assumes the analog core presents a sample on sample_data when asked.
`timescale 1ns/1ps
module adc_conv_ctl (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       standby,
  // CPU bus and trigger
  adc_bus_if.device       bus,
  // Analog core side
  input  wire logic [9:0] sample_data,
  output logic [3:0]      sample_channel,
  output logic            converting,
  output logic            shared_port_pin_is_trigger
);
  import adc_ctl_pkg::*;

  typedef enum logic {S_IDLE, S_CONV} conv_state_t;

  conv_state_t state;
  logic [7:0]  mode_status;
  logic        ext_trigger_enable;
  logic        conv_time_select;
  logic        conv_run;
  logic [9:0]  result [NUM_CHANNELS];
  logic [7:0]  low_latch;
  logic [8:0]  cnt;
  logic [1:0]  grp;
  logic [1:0]  idx;
  logic        trig_s1;
  logic        trig_s2;
  logic        trig_s3;
  logic        trig_fall;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        conv_last;
  logic        seq_last_idx;
  logic        seq_last_grp;
  logic [1:0]  first_grp;
  logic [1:0]  last_grp;
  logic [1:0]  first_idx;
  logic [1:0]  last_idx;
  logic [3:0]  rd_chan;
  logic [9:0]  rd_word;

  wire [1:0] conv_mode = mode_status[5:4];
  wire [3:0] chan_sel  = mode_status[3:0];

  assign wr_ctrl = bus.bus_wr && bus.bus_addr == OFS_CONTROL;
  assign wr_mode = bus.bus_wr && bus.bus_addr == OFS_MODE_STATUS;
  assign shared_port_pin_is_trigger = ext_trigger_enable;  // [R7]
  assign converting = state == S_CONV;

  // Sequence bounds per mode
  always_comb begin
    first_grp = 2'h0;
    last_grp  = 2'h0;
    first_idx = 2'h0;
    last_idx  = chan_sel[1:0];
    unique case (conv_mode)
      MODE_SINGLE: begin
        first_grp = chan_sel[3:2];  // [R1]
        last_grp  = chan_sel[3:2];
        first_idx = chan_sel[1:0];
      end
      MODE_SCAN4: begin
        first_grp = chan_sel[3:2];  // [R2]
        last_grp  = chan_sel[3:2];
      end
      MODE_SCAN8: begin
        last_grp = 2'h1;  // group-select bit ignored [R3]
      end
      MODE_SCAN12: begin
        last_grp = 2'h2;  // [R4]
      end
    endcase
  end

  assign seq_last_idx = idx == last_idx;
  assign seq_last_grp = grp == last_grp;
  assign conv_last    = state == S_CONV && cnt == 9'd1;

  // Trigger synchroniser; only the second and third stages are inspected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
    end else begin
      trig_s1 <= bus.ext_trigger_n;  // [R22]
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  assign trig_fall = trig_s3 && !trig_s2;

  // Mode/status register; end flag set beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_status <= MODE_ST_RESET;  // [R1] [R19]
    end else if (standby) begin
      mode_status <= MODE_ST_RESET;
    end else begin
      if (wr_mode) begin
        mode_status[6:0] <= bus.bus_wdata[6:0];
        if (!bus.bus_wdata[BIT_END_FLAG]) begin
          mode_status[BIT_END_FLAG] <= 1'b0;
        end
      end
      if (conv_last && seq_last_idx && seq_last_grp) begin
        mode_status[BIT_END_FLAG] <= 1'b1;
      end
    end
  end

  // Control register: trigger enable and time select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_trigger_enable <= CONTROL_RESET[BIT_EXT_TRIG];  // [R7]
      conv_time_select   <= CONTROL_RESET[BIT_TIME_SEL];  // [R11]
    end else if (standby) begin
      ext_trigger_enable <= CONTROL_RESET[BIT_EXT_TRIG];
      conv_time_select   <= CONTROL_RESET[BIT_TIME_SEL];
    end else if (wr_ctrl) begin
      ext_trigger_enable <= bus.bus_wdata[BIT_EXT_TRIG];
      conv_time_select   <= bus.bus_wdata[BIT_TIME_SEL];
    end
  end

  // Run bit: software write first, then trigger, then single-mode end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_run <= CONTROL_RESET[BIT_RUN];
    end else if (standby) begin
      conv_run <= CONTROL_RESET[BIT_RUN];
    end else if (wr_ctrl) begin
      conv_run <= bus.bus_wdata[BIT_RUN];  // [R12]
    end else if (ext_trigger_enable && trig_fall && !conv_run) begin
      conv_run <= 1'b1;  // edges while running are dropped [R8] [R9]
    end else if (conv_last && conv_mode == MODE_SINGLE) begin
      conv_run <= 1'b0;  // [R13]
    end
  end

  // Channel sequencer and conversion timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt   <= 9'd0;
      grp   <= 2'h0;
      idx   <= 2'h0;
    end else if (standby || !conv_run) begin
      state <= S_IDLE;  // clearing run stops even a scan [R12]
      cnt   <= 9'd0;
    end else if (state == S_IDLE) begin
      state <= S_CONV;
      grp   <= first_grp;
      idx   <= first_idx;
      cnt   <= conv_time_select ? CONV_FIRST_FAST : CONV_FIRST_SLOW;  // [R11]
    end else if (cnt != 9'd1) begin
      cnt <= cnt - 9'd1;
    end else if (conv_mode == MODE_SINGLE) begin
      state <= S_IDLE;  // [R13]
    end else begin
      // Ascending order: index within group, then next group [R21]
      cnt <= conv_time_select ? CONV_REPEAT_FAST : CONV_REPEAT_SLOW;
      if (!seq_last_idx) begin
        idx <= idx + 2'h1;
      end else begin
        idx <= 2'h0;
        grp <= seq_last_grp ? first_grp : grp + 2'h1;  // rerun the set [R13]
      end
    end
  end
  assign sample_channel = {grp, idx};

  // Result store; a sample whose index is twelve or more is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result[i] <= 10'h000;
      end
    end else if (standby) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result[i] <= 10'h000;
      end
    end else if (conv_last && sample_channel < 4'(NUM_CHANNELS)) begin
      result[sample_channel] <= sample_data;
    end
  end

  assign rd_chan = bus.bus_addr[4:1];
  assign rd_word = (rd_chan < 4'(NUM_CHANNELS)) ? result[rd_chan] : 10'h000;

  // Lower-byte latch loaded by an upper-byte read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_latch <= 8'h00;
    end else if (bus.bus_rd && bus.bus_addr < OFS_MODE_STATUS && !bus.bus_addr[0]) begin
      low_latch <= {rd_word[1:0], 6'h00};  // [R15] [R20]
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.bus_rdata  <= 8'h00;
      bus.bus_rvalid <= 1'b0;
    end else begin
      bus.bus_rvalid <= bus.bus_rd;
      if (bus.bus_rd) begin
        if (bus.bus_addr == OFS_CONTROL) begin
          bus.bus_rdata <= {ext_trigger_enable, conv_time_select, conv_run,
                            CONTROL_RSVD};  // [R6]
        end else if (bus.bus_addr == OFS_MODE_STATUS) begin
          bus.bus_rdata <= mode_status;
        end else if (bus.bus_addr > OFS_CONTROL) begin
          bus.bus_rdata <= 8'h00;
        end else if (!bus.bus_addr[0]) begin
          bus.bus_rdata <= rd_word[9:2];  // [R14] [R20]
        end else begin
          bus.bus_rdata <= low_latch;  // [R16]
        end
      end
    end
  end
endmodule

//--- include/adc_ctl_pkg.sv
// Constants shared by the converter control end and the CPU-side controller.
// Assumes one clock (pclk, 20 MHz) and an asynchronous active-low reset.
// How it works
// (R1) Single mode: four select bits pick one input.
// (R2) Four-scan: group from top bits, count from low.
// (R3) Eight-scan: groups 0,1; top select bit never set.
// (R4) Twelve-scan: three groups; top bit set forces next zero.
// (R5) Change time, mode, channels only while stopped.
// (R6) Control resets 0x1F; low five bits read one.
// (R7) Bit 7 enables trigger, takes over port pin.
// (R8) Trigger falling edge sets the run bit.
// (R9) Trigger edge ignored while run bit is set.
// (R10) Trigger low pulse lasts at least 1.5 clocks.
// (R11) Bit 6 picks 266 or 134 state conversion.
// (R12) Bit 5 run: write one starts, zero stops.
// (R13) Single clears run at end; scan repeats.
// (R14) Result words read as two separate bytes.
// (R15) Upper byte read also loads lower-byte latch.
// (R16) Lower byte read returns the latch.
// (R17) Software reads upper byte before lower byte.
// (R18) Word read is upper access then lower.
// (R19) Mode bits: single, four, eight, twelve scan.
// (R20) Ten-bit result stored left-justified, rest zero.
// (R21) Scan converts channels in ascending order.
// (R22) Trigger input synchronised before edge detection.
package adc_ctl_pkg;
  // Byte map on the internal eight-bit bus
  localparam int         ADDR_W          = 5;
  localparam logic [4:0] OFS_RESULT_BASE = 5'h00;  // result n: high at 2n, low at 2n+1
  localparam logic [4:0] OFS_MODE_STATUS = 5'h18;
  localparam logic [4:0] OFS_CONTROL     = 5'h19;
  localparam int         NUM_CHANNELS    = 12;
  // Field positions
  localparam int BIT_EXT_TRIG = 7;
  localparam int BIT_TIME_SEL = 6;
  localparam int BIT_RUN      = 5;
  localparam int BIT_END_FLAG = 7;
  localparam int BIT_INT_EN   = 6;
  // Values after reset
  localparam logic [7:0] CONTROL_RESET  = 8'h1F;
  localparam logic [4:0] CONTROL_RSVD   = 5'h1F;
  localparam logic [7:0] MODE_ST_RESET  = 8'h00;
  // Mode encodings
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SCAN4  = 2'h1;
  localparam logic [1:0] MODE_SCAN8  = 2'h2;
  localparam logic [1:0] MODE_SCAN12 = 2'h3;
  // Conversion times in states (one state is one pclk)
  localparam logic [8:0] CONV_FIRST_SLOW  = 9'd266;
  localparam logic [8:0] CONV_FIRST_FAST  = 9'd134;
  localparam logic [8:0] CONV_REPEAT_SLOW = 9'd256;
  localparam logic [8:0] CONV_REPEAT_FAST = 9'd128;
  // Trigger low pulse: 1.5 clocks, rounded up
  localparam int         TRIG_LOW_TENTHS = 15;
  localparam logic [1:0] TRIG_LOW_CYCLES = 2'((TRIG_LOW_TENTHS + 9) / 10);
  // Controller APB map
  localparam logic [7:0] APB_BYTE_ADDR = 8'h00;
  localparam logic [7:0] APB_WDATA     = 8'h04;
  localparam logic [7:0] APB_COMMAND   = 8'h08;
  localparam logic [7:0] APB_STATUS    = 8'h0C;
  localparam logic [7:0] APB_TRIGGER   = 8'h10;
endpackage

//--- include/adc_bus_if.sv
// Internal eight-bit CPU bus plus the external trigger line.
// Assumes both ends share pclk; the bench joins them through this interface.
`timescale 1ns/1ps
interface adc_bus_if;
  logic [4:0] bus_addr;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic       bus_rvalid;
  logic       ext_trigger_n;
  modport device (input bus_addr, bus_wr, bus_rd, bus_wdata, ext_trigger_n,
                  output bus_rdata, bus_rvalid);
  modport host   (output bus_addr, bus_wr, bus_rd, bus_wdata, ext_trigger_n,
                  input bus_rdata, bus_rvalid);
endinterface

//--- logic/adc_cpu_ctl.sv
// CPU-side controller: APB slave whose commands become byte accesses on
// the internal bus, plus a trigger pulse generator.
// Assumes the far end answers a read one cycle after its strobe.
`timescale 1ns/1ps
module adc_cpu_ctl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Internal bus toward the converter
  adc_bus_if.host          bus
);
  import adc_ctl_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_CHK, H_CHK_CAP, H_WR, H_RD1, H_RD2, H_RD_CAP}
    host_state_t;

  host_state_t state;
  logic [4:0]  byte_addr;
  logic [7:0]  wdata;
  logic        word_rd;
  logic [15:0] rd_data;
  logic        refused;
  logic [1:0]  trig_cnt;
  logic        apb_wr;
  logic        mapped;
  logic        bad_mode;

  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = paddr == APB_BYTE_ADDR || paddr == APB_WDATA || paddr == APB_COMMAND
                || paddr == APB_STATUS || paddr == APB_TRIGGER;
  assign pslverr = psel && penable && !mapped;

  // Forbidden select codes: top bit with next bit, or top bit in eight-scan
  assign bad_mode = (wdata[3] && wdata[2])  // [R4]
                 || (wdata[5:4] == MODE_SCAN8 && wdata[3]);  // [R3]

  // Setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_addr <= 5'h00;
      wdata     <= 8'h00;
    end else if (apb_wr && paddr == APB_BYTE_ADDR) begin
      byte_addr <= pwdata[4:0];
    end else if (apb_wr && paddr == APB_WDATA) begin
      wdata <= pwdata[7:0];
    end
  end

  // Access sequencer; commands while busy are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= H_IDLE;
      word_rd <= 1'b0;
      rd_data <= 16'h0000;
      refused <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (apb_wr && paddr == APB_COMMAND) begin
            word_rd <= pwdata[2];
            if (pwdata[0]) begin
              refused <= 1'b0;
              state   <= H_CHK;  // writes check the run bit first
            end else if (pwdata[1] || pwdata[2]) begin
              state <= H_RD1;
            end
          end
        end
        H_CHK:     state <= H_CHK_CAP;
        H_CHK_CAP: begin
          // Stopped converter required for time, mode or channel edits [R5]
          if (byte_addr == OFS_MODE_STATUS
              && (bus.bus_rdata[BIT_RUN] || bad_mode)) begin
            refused <= 1'b1;
            state   <= H_IDLE;
          end else if (byte_addr == OFS_CONTROL && bus.bus_rdata[BIT_RUN]
                       && wdata[BIT_TIME_SEL] != bus.bus_rdata[BIT_TIME_SEL]) begin
            refused <= 1'b1;
            state   <= H_IDLE;
          end else begin
            state <= H_WR;
          end
        end
        H_WR:  state <= H_IDLE;
        H_RD1: state <= word_rd ? H_RD2 : H_RD_CAP;
        H_RD2: begin
          rd_data[15:8] <= bus.bus_rdata;  // upper byte first [R17] [R18]
          state         <= H_RD_CAP;
        end
        H_RD_CAP: begin
          if (word_rd) begin
            rd_data[7:0] <= bus.bus_rdata;
          end else begin
            rd_data <= {8'h00, bus.bus_rdata};
          end
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Bus drive; word reads force the upper byte, then the lower [R18]
  always_comb begin
    bus.bus_wr    = state == H_WR;
    bus.bus_rd    = state == H_CHK || state == H_RD1 || state == H_RD2;
    bus.bus_wdata = wdata;
    bus.bus_addr  = byte_addr;
    if (state == H_CHK) begin
      bus.bus_addr = OFS_CONTROL;
    end else if (state == H_RD1 && word_rd) begin
      bus.bus_addr = {byte_addr[4:1], 1'b0};
    end else if (state == H_RD2) begin
      bus.bus_addr = {byte_addr[4:1], 1'b1};
    end
  end

  // Trigger low pulse, held long enough to be sampled [R10]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_cnt <= 2'h0;
    end else if (apb_wr && paddr == APB_TRIGGER && pwdata[0] && trig_cnt == 2'h0) begin
      trig_cnt <= TRIG_LOW_CYCLES;
    end else if (trig_cnt != 2'h0) begin
      trig_cnt <= trig_cnt - 2'h1;
    end
  end
  assign bus.ext_trigger_n = trig_cnt == 2'h0;

  // APB read mux over flip-flop contents
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      APB_BYTE_ADDR: prdata = {27'h0, byte_addr};
      APB_WDATA:     prdata = {24'h0, wdata};
      APB_STATUS:    prdata = {8'h00, rd_data, 6'h00, refused, state != H_IDLE};
      APB_TRIGGER:   prdata = {31'h0, trig_cnt != 2'h0};
      default:       prdata = 32'h0000_0000;
    endcase
  end
endmodule

//--- tb/adc_ctl_chk.sv
// Checker for the internal byte bus and trigger line between both ends.
// Assumes one clock, pclk, and sees only interface signals.
`timescale 1ns/1ps
module adc_ctl_chk
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Internal bus and trigger
  input wire logic [4:0] bus_addr,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic       bus_rvalid,
  input wire logic       ext_trigger_n
);
  logic [7:0] ctl_w;
  logic [4:0] last_rd;
  logic       ctl_rd;
  logic       low_rd;
  logic       mode_wr;
  logic       bad_sel;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Last control write; apart from standby, hardware never alters bits 7 and 6
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_w <= CONTROL_RESET;
    else if (bus_wr && bus_addr == OFS_CONTROL) ctl_w <= bus_wdata;
  end

  // Last read address, to see the high byte go first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_rd <= 5'h1F;
    else if (bus_rd) last_rd <= bus_addr;
  end

  // Strobes the properties key on; kept short so each label line holds its tag
  assign ctl_rd  = bus_rd && bus_addr == OFS_CONTROL;
  assign low_rd  = bus_rd && bus_addr < OFS_MODE_STATUS && bus_addr[0];
  assign mode_wr = bus_wr && bus_addr == OFS_MODE_STATUS;
  assign bad_sel = bus_wdata[3] && (bus_wdata[2] || bus_wdata[5:4] == MODE_SCAN8);

  sequence trig_low_two;
    !ext_trigger_n [*2];
  endsequence
  sequence trig_back_high;
    ext_trigger_n;
  endsequence

  chk_rd_answer: assert property (bus_rd |=> bus_rvalid)
    else $error("read strobe not answered next cycle");
  chk_no_stray: assert property (bus_rvalid |-> $past(bus_rd))
    else $error("read answer without strobe");
  chk_ctrl_ones: assert property (ctl_rd |=> bus_rdata[4:0] == 5'h1F)
    else $error("control low bits not all ones");
  chk_ctrl_kept: assert property (ctl_rd |=> bus_rdata[7:6] == ctl_w[7:6])
    else $error("control top bits differ from last write");
  chk_low_pad: assert property (low_rd |=> bus_rdata[5:0] == 6'h00)
    else $error("low result byte padding not zero");
  chk_high_first: assert property (low_rd |-> last_rd == {bus_addr[4:1], 1'b0})
    else $error("low byte read without its high byte first");
  chk_trig_pulse: assert property ($fell(ext_trigger_n) |-> trig_low_two ##1 trig_back_high)
    else $error("trigger low pulse not two cycles");
  chk_sel_legal: assert property (mode_wr |-> !bad_sel)
    else $error("illegal select code written");
endmodule

//--- tb/testbench.sv
// Bench joining both ends; drives the host over APB and watches the converter.
// Assumes the designer's map and one 20 MHz clock.
`timescale 1ns/1ps
module testbench;
  import adc_ctl_pkg::*;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        standby     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [9:0]  sample_data = 10'h2A5;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sample_channel;
  logic        converting;
  logic        port_trig;
  logic [31:0] st;
  logic        e;
  int          err_count   = 0;
  int          comparisons = 0;

  adc_bus_if bus_if ();
  adc_conv_ctl adc_conv_ctl_inst (.pclk(pclk), .presetn(presetn), .standby(standby),
    .bus(bus_if), .sample_data(sample_data), .sample_channel(sample_channel),
    .converting(converting), .shared_port_pin_is_trigger(port_trig));
  adc_cpu_ctl adc_cpu_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if));
  adc_ctl_chk adc_ctl_chk_inst (.pclk(pclk), .presetn(presetn), .bus_addr(bus_if.bus_addr),
    .bus_wr(bus_if.bus_wr), .bus_rd(bus_if.bus_rd), .bus_wdata(bus_if.bus_wdata),
    .bus_rdata(bus_if.bus_rdata), .bus_rvalid(bus_if.bus_rvalid),
    .ext_trigger_n(bus_if.ext_trigger_n));

  // 50 ns period
  always #25 pclk = ~pclk;

  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task hang(input string what);
    err_count++;
    $display("BAD t=%0t no answer: %s", $time, what);
    test_done();
  endtask

  // One APB transfer; entered just after a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("pready");
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Byte command through the host; returns status once idle
  task cmd(input logic [4:0] a, input logic [7:0] d, input logic [31:0] c,
           output logic [31:0] s);
    logic [31:0] r;
    logic        x;
    int          i;
    apb(APB_BYTE_ADDR, 1'b1, {27'h0, a}, r, x);
    apb(APB_WDATA, 1'b1, {24'h0, d}, r, x);
    apb(APB_COMMAND, 1'b1, c, r, x);
    for (i = 0; i < 20; i++) begin
      apb(APB_STATUS, 1'b0, 32'h0, s, x);
      if (s[0] === 1'b0) break;
    end
    if (i == 20) hang("busy");
  endtask

  task rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
    cmd(a, 8'h00, 32'h2, st);
    chk({24'h0, st[15:8]}, {24'h0, exp}, what);
  endtask

  task wait_conv(input logic v, input int bound);
    int i;
    for (i = 0; i < bound && converting !== v; i++) @(posedge pclk);
    if (converting !== v) hang("converting");
  endtask

  // Start a run and compare the channels in the order they are converted
  task scan(input logic [7:0] ms, input int n, input logic [23:0] exp);
    logic [3:0] last;
    logic       was;
    int         i;
    int         k;
    cmd(OFS_MODE_STATUS, ms, 32'h1, st);
    cmd(OFS_CONTROL, 8'h60, 32'h1, st);
    was  = 1'b0;
    last = 4'h0;
    k    = 0;
    for (i = 0; i < 2000 && k < n; i++) begin
      @(posedge pclk);
      if (converting === 1'b1 && (!was || sample_channel !== last)) begin
        chk({28'h0, sample_channel}, {28'h0, exp[23 - 4*k -: 4]}, "channel");
        last = sample_channel;
        k++;
      end
      was = converting;
    end
    if (k < n) hang("scan");
  endtask

  task stop_run;
    cmd(OFS_CONTROL, 8'h40, 32'h1, st);
    wait_conv(1'b0, 20);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFS_CONTROL, 8'h1F, "control reset");
    rd_chk(OFS_MODE_STATUS, 8'h00, "mode reset");
    cmd(5'h04, 8'h00, 32'h4, st);
    chk({16'h0, st[23:8]}, 32'h0, "result reset");
    apb(8'h20, 1'b0, 32'h0, st, e);
    chk({31'h0, e}, 32'h1, "unmapped slverr");
    cmd(OFS_CONTROL, 8'h40, 32'h1, st);
    rd_chk(OFS_CONTROL, 8'h5F, "reserved ones");
    chk({31'h0, port_trig}, 32'h0, "pin not trigger");
    // Single conversion of input 2, then the split word read
    scan(8'h02, 1, 24'h200000);
    wait_conv(1'b0, 150);
    rd_chk(OFS_CONTROL, 8'h5F, "run cleared");
    rd_chk(OFS_MODE_STATUS, 8'h82, "end flag");
    cmd(5'h04, 8'h00, 32'h4, st);
    chk({16'h0, st[23:8]}, 32'hA940, "word result");
    scan(8'h15, 3, 24'h454000);
    rd_chk(OFS_CONTROL, 8'h7F, "run kept");
    // Live value changes between the two byte reads; the latch must not
    rd_chk(5'h08, 8'hA9, "upper byte of input 4");
    sample_data <= 10'h0FF;
    repeat (300) @(posedge pclk);
    rd_chk(5'h09, 8'h40, "lower byte from latch");
    stop_run();
    scan(8'h21, 5, 24'h014500);
    stop_run();
    scan(8'h39, 6, 24'h014589);
    cmd(OFS_MODE_STATUS, 8'h00, 32'h1, st);
    chk({31'h0, st[1]}, 32'h1, "change while running");
    stop_run();
    cmd(OFS_MODE_STATUS, 8'h2B, 32'h1, st);
    chk({31'h0, st[1]}, 32'h1, "reserved eight-scan code");
    cmd(OFS_MODE_STATUS, 8'h3C, 32'h1, st);
    chk({31'h0, st[1]}, 32'h1, "top two select bits");
    // External trigger; a second edge during the run is dropped
    cmd(OFS_MODE_STATUS, 8'h00, 32'h1, st);
    cmd(OFS_CONTROL, 8'hC0, 32'h1, st);
    chk({31'h0, port_trig}, 32'h1, "pin is trigger");
    apb(APB_TRIGGER, 1'b1, 32'h1, st, e);
    wait_conv(1'b1, 30);
    apb(APB_TRIGGER, 1'b1, 32'h1, st, e);
    wait_conv(1'b0, 300);
    repeat (20) @(posedge pclk);
    chk({31'h0, converting}, 32'h0, "edge ignored while running");
    // Standby returns registers and results to reset values
    cmd(OFS_CONTROL, 8'h00, 32'h1, st);
    standby <= 1'b1;
    repeat (2) @(posedge pclk);
    standby <= 1'b0;
    @(posedge pclk);
    rd_chk(OFS_CONTROL, 8'h1F, "control after standby");
    rd_chk(OFS_MODE_STATUS, 8'h00, "mode after standby");
    cmd(5'h00, 8'h00, 32'h4, st);
    chk({16'h0, st[23:8]}, 32'h0, "result after standby");
    test_done();
  end
endmodule
